// ### pkg/sacu_cfg.svh
`ifndef SACU_CFG_SVH
`define SACU_CFG_SVH

// Host port addresses.
`define SACU_ADDR_DATA 1'b0
`define SACU_ADDR_CTRL 1'b1

// Command codes with the service request flag stripped off.
`define SACU_SRQ_BIT 7
`define SACU_OPC_ADD 7'h6C
`define SACU_OPC_SUB 7'h6D
`define SACU_OPC_MULL 7'h6E
`define SACU_OPC_DIV 7'h6F
`define SACU_OPC_MULH 7'h76
`define SACU_OPC_FLOAT_ROOT_TWO 7'h01
`define SACU_OPC_SIN 7'h02
`define SACU_OPC_TAN 7'h04
`define SACU_OPC_SWAPD 7'h39
`define SACU_OPC_SWAPF 7'h19
`define SACU_OPC_SWAPS 7'h79

// Status byte layout and error codes.
`define SACU_ST_BUSY 7
`define SACU_ST_SIGN 6
`define SACU_ST_ZERO 5
`define SACU_ST_ERR_HI 4
`define SACU_ST_ERR_LO 1
`define SACU_ST_CARRY 0
`define SACU_ERR_NONE 4'h0
`define SACU_ERR_OVF 4'h2
`define SACU_ERR_NEG 4'h4
`define SACU_ERR_DIVZ 4'h8

// Execution times in clock cycles.
`define SACU_CYC_ADD 13'h0010
`define SACU_CYC_SUB 13'h001E
`define SACU_CYC_MULL 13'h0054
`define SACU_CYC_MULH 13'h0050
`define SACU_CYC_DIV 13'h0054
`define SACU_CYC_DIVZ 13'h000E
`define SACU_CYC_FLOAT_ROOT_TWO 13'h030E
`define SACU_CYC_SIN 13'h0ED4
`define SACU_CYC_TAN 13'h131E
`define SACU_CYC_SMALL 13'h001E
`define SACU_CYC_SWAP32 13'h001A
`define SACU_CYC_SWAP16 13'h0012

// Fixed and floating constants.
`define SACU_MIN_NEG 16'h8000
`define SACU_SMALL_EXP 7'h75
`define SACU_HALF_MANT 24'h80_0000
`define SACU_HALF_PI 32'h01C9_0FDB

`endif

// ### pkg/sacu_pkg.sv
package sacu_pkg;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } sacu_state_type;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_ADD,
    OP_SUB,
    OP_DIV,
    OP_MULL,
    OP_MULH,
    OP_FLOAT_ROOT_TWO,
    OP_SIN,
    OP_TAN,
    OP_SWAP32,
    OP_SWAP16
  } sacu_op_type;

  typedef struct packed {
    sacu_state_type state;
    sacu_op_type op;
    logic srq_req;
    logic [12:0] timer;
    logic [12:0] run_len;
    logic [2:0] ptr;
    logic [7:0][15:0] stk;
    logic [6:0] status;
    logic [15:0] rd_data;
    logic stall;
    logic srq;
    logic ack_s1;
    logic ack_s2;
  } sacu_regs_type;

endpackage

// ### verilog/sacu_fixed_alu.sv
`timescale 1ns/1ps
`include "sacu_cfg.svh"

module sacu_fixed_alu
  import sacu_pkg::*;
(
  // Operation select
  input wire sacu_op_type op,
  // Operands: a is the stack head, b the entry below it
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  // Result and status contributions
  output logic [15:0] result,
  output logic carry,
  output logic [3:0] err
);

  logic [16:0] sum;
  logic [16:0] diff;
  logic signed [31:0] prod;
  logic [15:0] divisor;
  logic signed [15:0] quot;
  logic min_in;
  logic ovf;

  always_comb begin
    sum = {1'b0, b} + {1'b0, a};
    diff = {1'b0, b} - {1'b0, a};
    prod = $signed(a) * $signed(b);
    // A zero divisor is replaced so the divider never sees it.
    divisor = (a == 16'h0000) ? 16'h0001 : a;
    quot = $signed(b) / $signed(divisor);
    min_in = (a == `SACU_MIN_NEG) || (b == `SACU_MIN_NEG);
    result = 16'h0000;
    carry = 1'b0;
    ovf = 1'b0;
    err = `SACU_ERR_NONE;
    case (op)
      OP_ADD: begin
        result = sum[15:0];
        carry = sum[16];
        ovf = (a[15] == b[15]) && (sum[15] != b[15]);
      end
      OP_SUB: begin
        result = diff[15:0];
        carry = diff[16];
        ovf = (a == `SACU_MIN_NEG) ||
              ((a[15] != b[15]) && (diff[15] != b[15]));
      end
      OP_MULL: begin
        result = min_in ? `SACU_MIN_NEG : prod[15:0];
        ovf = min_in || (prod[31:16] != 16'h0000);
      end
      OP_MULH: begin
        result = min_in ? `SACU_MIN_NEG : prod[31:16];
        ovf = min_in;
      end
      OP_DIV: begin
        result = (a == 16'h0000) ? b : quot;
      end
      default: begin
        result = 16'h0000;
      end
    endcase
    if (op == OP_DIV && a == 16'h0000) begin
      err = `SACU_ERR_DIVZ;
    end else if (ovf) begin
      err = `SACU_ERR_OVF;
    end
  end

endmodule

// ### verilog/sacu_core.sv
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "sacu_cfg.svh"

// How it works
// - Opcode bit 7 set raises service request at end; clear keeps it low.
// - Fixed add decodes as EC or 6C and takes 16 cycles.
// - Add puts A plus B in B's place, pops, reports carry, overflow.
// - Fixed divide decodes EF or 6F; 84 cycles, 14 on zero divisor.
// - Divide gives B over A truncated; zero divisor returns B, flags error.
// - Sine decodes 82 or 02; 3796 cycles, 30 for tiny arguments.
// - Sine replaces the 32-bit head, touching only sign and zero.
// - Low multiply decodes EE or 6E and takes 84 cycles.
// - Low multiply keeps low half, or minimum for a minimum operand; flags discarded upper half or minimum.
// - High multiply decodes F6 or 76 and takes 80 cycles.
// - High multiply keeps upper half; minimum operand gives it, overflow.
// - Square root decodes 81 or 01 and takes 782 cycles.
// - Square root replaces head; negative head gives error code 0100.
// - Fixed subtract decodes ED or 6D and takes 30 cycles.
// - Subtract gives B minus A, borrow in carry, overflow on range.
// - Tangent decodes 84 or 04; 4894 cycles, 30 for tiny arguments.
// - Tangent keeps its argument as the result; tiny arguments return themselves.
// - Tangent of an argument matching half pi in bits 30 to 8, of either sign, sets overflow.
// - Both 32-bit exchanges, B9/39 and 99/19, behave alike in 26 cycles.
// - 32-bit exchange swaps head pair, updating only sign and zero.
// - 16-bit exchange decodes F9 or 79 and takes 18 cycles.
// - 16-bit exchange swaps head and next, updating only sign and zero.
module sacu_core
  import sacu_pkg::*;
#(
  parameter logic [12:0] TAN_CYCLES = `SACU_CYC_TAN
)
(
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  // Host register port
  input wire logic addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [15:0] rd_data,
  // Handshake with the host
  output logic stall,
  output logic srq,
  input wire logic svc_ack
);

  sacu_regs_type r;
  sacu_regs_type next_r;
  sacu_op_type dec_op;
  sacu_op_type alu_op;
  logic [15:0] alu_res;
  logic alu_carry;
  logic [3:0] alu_err;
  logic [2:0] i1;
  logic [2:0] i2;
  logic [2:0] i3;
  logic [15:0] a16;
  logic [15:0] b16;
  logic [31:0] a32;
  logic [31:0] b32;
  logic [31:0] f_res;
  logic accept;
  logic done;

  function automatic logic [2:0] idx(input logic [2:0] p,
                                     input logic [2:0] k);
    return p - k;
  endfunction

  function automatic sacu_op_type decode(input logic [6:0] opc);
    case (opc)
      `SACU_OPC_ADD: return OP_ADD;
      `SACU_OPC_SUB: return OP_SUB;
      `SACU_OPC_DIV: return OP_DIV;
      `SACU_OPC_MULL: return OP_MULL;
      `SACU_OPC_MULH: return OP_MULH;
      `SACU_OPC_FLOAT_ROOT_TWO: return OP_FLOAT_ROOT_TWO;
      `SACU_OPC_SIN: return OP_SIN;
      `SACU_OPC_TAN: return OP_TAN;
      `SACU_OPC_SWAPD: return OP_SWAP32;
      `SACU_OPC_SWAPF: return OP_SWAP32;
      `SACU_OPC_SWAPS: return OP_SWAP16;
      default: return OP_NONE;
    endcase
  endfunction

  // True for a floating argument of magnitude at most two to the -12.
  function automatic logic is_small(input logic [31:0] f);
    logic signed [6:0] e;
    e = f[30:24];
    return (f[23:0] == 24'h00_0000) ||
           (e < $signed(`SACU_SMALL_EXP)) ||
           (e == $signed(`SACU_SMALL_EXP) &&
            f[23:0] == `SACU_HALF_MANT);
  endfunction

  function automatic logic [12:0] cycles(input sacu_op_type op,
                                         input logic [15:0] top,
                                         input logic [31:0] top32);
    case (op)
      OP_ADD: return `SACU_CYC_ADD;
      OP_SUB: return `SACU_CYC_SUB;
      OP_MULL: return `SACU_CYC_MULL;
      OP_MULH: return `SACU_CYC_MULH;
      OP_DIV: return (top == 16'h0000) ? `SACU_CYC_DIVZ
                                       : `SACU_CYC_DIV;
      OP_FLOAT_ROOT_TWO: return `SACU_CYC_FLOAT_ROOT_TWO;
      OP_SIN: return is_small(top32) ? `SACU_CYC_SMALL
                                     : `SACU_CYC_SIN;
      OP_TAN: return is_small(top32) ? `SACU_CYC_SMALL
                                     : TAN_CYCLES;
      OP_SWAP32: return `SACU_CYC_SWAP32;
      OP_SWAP16: return `SACU_CYC_SWAP16;
      default: return 13'd1;
    endcase
  endfunction

  // Integer root of a 48-bit value, one result bit per step.
  function automatic logic [23:0] isqrt(input logic [47:0] v);
    logic [25:0] rem;
    logic [25:0] trial;
    logic [23:0] root;
    rem = '0;
    root = '0;
    for (int i = 23; i >= 0; i--) begin
      rem = {rem[23:0], v[2*i+1], v[2*i]};
      trial = {root, 2'b01};
      if (rem >= trial) begin
        rem = rem - trial;
        root = {root[22:0], 1'b1};
      end else begin
        root = {root[22:0], 1'b0};
      end
    end
    return root;
  endfunction

  // Odd exponents shift the mantissa so the halved exponent stays exact.
  function automatic logic [31:0] froot(input logic [31:0] f);
    logic [7:0] e8;
    logic [23:0] m;
    e8 = {f[30], f[30:24]} + {7'h00, f[24]};
    m = f[24] ? isqrt({1'b0, f[23:0], 23'h00_0000})
              : isqrt({f[23:0], 24'h00_0000});
    return (f[23:0] == 24'h00_0000) ? 32'h0000_0000
                                    : {1'b0, e8[7:1], m};
  endfunction

  // Ring addressing: the head is at ptr and older entries sit below it.
  always_comb begin
    i1 = idx(r.ptr, 3'h1);
    i2 = idx(r.ptr, 3'h2);
    i3 = idx(r.ptr, 3'h3);
    a16 = r.stk[r.ptr];
    b16 = r.stk[i1];
    a32 = {r.stk[r.ptr], r.stk[i1]};
    b32 = {r.stk[i2], r.stk[i3]};
    dec_op = decode(wr_data[6:0]);
    alu_op = r.op;
    accept = ce && r.state == ST_IDLE && wr_strobe &&
             addr == `SACU_ADDR_CTRL && dec_op != OP_NONE;
    done = ce && r.state == ST_EXEC && r.timer == 13'd0;
  end

  sacu_fixed_alu u_alu (
    .op(alu_op),
    .a(a16),
    .b(b16),
    .result(alu_res),
    .carry(alu_carry),
    .err(alu_err)
  );

  // Only the tiny-argument path returns an exact value for the circular
  // functions; larger arguments keep the argument as a stand-in.
  always_comb begin
    case (r.op)
      OP_FLOAT_ROOT_TWO: f_res = a32[31] ? a32 : froot(a32);
      default: f_res = a32;
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.ack_s1 = svc_ack;
    next_r.ack_s2 = r.ack_s1;
    if (r.ack_s2) begin
      next_r.srq = 1'b0;
    end
    case (r.state)
      ST_IDLE: begin
        if (accept) begin
          next_r.state = ST_EXEC;
          next_r.op = dec_op;
          next_r.srq_req = wr_data[`SACU_SRQ_BIT];
          next_r.srq = 1'b0;
          next_r.timer = cycles(dec_op, a16, a32) - 13'd1;
          next_r.run_len = 13'd1;
          next_r.stall = 1'b1;
        end else if (wr_strobe && addr == `SACU_ADDR_DATA) begin
          next_r.ptr = r.ptr + 3'h1;
          next_r.stk[r.ptr + 3'h1] = wr_data;
        end
        if (rd_strobe && addr == `SACU_ADDR_DATA) begin
          next_r.rd_data = a16;
          next_r.ptr = i1;
        end
      end
      ST_EXEC: begin
        // Data traffic is refused while a command runs.
        next_r.timer = r.timer - 13'd1;
        next_r.run_len = r.run_len + 13'd1;
        if (rd_strobe && addr == `SACU_ADDR_DATA) begin
          next_r.rd_data = 16'h0000;
        end
        if (r.timer == 13'd0) begin
          next_r.state = ST_IDLE;
          next_r.stall = 1'b0;
          if (r.srq_req) begin
            next_r.srq = 1'b1;
          end
          case (r.op)
            OP_ADD, OP_SUB, OP_DIV, OP_MULL, OP_MULH: begin
              next_r.stk[i1] = alu_res;
              next_r.ptr = i1;
              next_r.status[`SACU_ST_SIGN] = alu_res[15];
              next_r.status[`SACU_ST_ZERO] = alu_res == 16'h0000;
              next_r.status[`SACU_ST_ERR_HI:`SACU_ST_ERR_LO] = alu_err;
              if (r.op == OP_ADD || r.op == OP_SUB) begin
                next_r.status[`SACU_ST_CARRY] = alu_carry;
              end
            end
            OP_FLOAT_ROOT_TWO, OP_SIN, OP_TAN: begin
              next_r.stk[r.ptr] = f_res[31:16];
              next_r.stk[i1] = f_res[15:0];
              next_r.status[`SACU_ST_SIGN] = f_res[31];
              next_r.status[`SACU_ST_ZERO] = f_res[23:0] == 24'h00_0000;
              if (r.op == OP_FLOAT_ROOT_TWO) begin
                next_r.status[`SACU_ST_ERR_HI:`SACU_ST_ERR_LO] =
                  a32[31] ? `SACU_ERR_NEG : `SACU_ERR_NONE;
              end
              if (r.op == OP_TAN) begin
                next_r.status[`SACU_ST_ERR_HI:`SACU_ST_ERR_LO] =
                  (a32[30:8] == `SACU_HALF_PI >> 8) ?
                  `SACU_ERR_OVF : `SACU_ERR_NONE;
              end
            end
            OP_SWAP32: begin
              next_r.stk[r.ptr] = b32[31:16];
              next_r.stk[i1] = b32[15:0];
              next_r.stk[i2] = a32[31:16];
              next_r.stk[i3] = a32[15:0];
              next_r.status[`SACU_ST_SIGN] = b32[31];
              next_r.status[`SACU_ST_ZERO] = b32[23:0] == 24'h00_0000;
            end
            OP_SWAP16: begin
              next_r.stk[r.ptr] = b16;
              next_r.stk[i1] = a16;
              next_r.status[`SACU_ST_SIGN] = b16[15];
              next_r.status[`SACU_ST_ZERO] = b16 == 16'h0000;
            end
            default: begin
              next_r.op = OP_NONE;
            end
          endcase
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
    // Status may be read at any time; busy shows the running command.
    if (rd_strobe && addr == `SACU_ADDR_CTRL) begin
      next_r.rd_data = {8'h00, r.state == ST_EXEC, r.status};
    end
  end

  // Reset wins over the enable so a frozen block can still be cleared.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign rd_data = r.rd_data;
  assign stall = r.stall;
  assign srq = r.srq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_accept;
    accept;
  endsequence

  sequence s_finish(sacu_op_type o);
    done && r.op == o;
  endsequence

  a_srq_on_done:
  assert property (done && r.srq_req |=> srq)
    else $error("service request missing after flagged command");

  a_srq_kept_low:
  assert property (s_accept ##0 !wr_data[7] |=> !srq [*2])
    else $error("service request rose for unflagged command");

  a_add_length:
  assert property (s_finish(OP_ADD) |-> r.run_len == `SACU_CYC_ADD)
    else $error("add took the wrong number of cycles");

  a_add_value:
  assert property (s_finish(OP_ADD) |=>
    r.stk[r.ptr] == $past(alu_res) && r.ptr == $past(i1))
    else $error("add result or stack move wrong");

  a_div_length:
  assert property (s_finish(OP_DIV) |-> r.run_len ==
    ((a16 == 16'h0000) ? `SACU_CYC_DIVZ : `SACU_CYC_DIV))
    else $error("divide took the wrong number of cycles");

  a_div_by_zero:
  assert property (s_finish(OP_DIV) && a16 == 16'h0000 |=>
    r.stk[r.ptr] == $past(b16) &&
    r.status[`SACU_ST_ERR_HI:`SACU_ST_ERR_LO] == `SACU_ERR_DIVZ)
    else $error("zero divisor not handled");

  a_sin_length:
  assert property (s_finish(OP_SIN) |-> r.run_len ==
    (is_small(a32) ? `SACU_CYC_SMALL : `SACU_CYC_SIN))
    else $error("sine took the wrong number of cycles");

  a_mulh_minimum:
  assert property (s_finish(OP_MULH) &&
    (a16 == `SACU_MIN_NEG || b16 == `SACU_MIN_NEG) |=>
    r.stk[r.ptr] == `SACU_MIN_NEG)
    else $error("high multiply of minimum value wrong");

  a_float_root_two_length:
  assert property (s_finish(OP_FLOAT_ROOT_TWO) |-> r.run_len == `SACU_CYC_FLOAT_ROOT_TWO)
    else $error("square root took the wrong number of cycles");

  a_sub_length:
  assert property (s_finish(OP_SUB) |-> r.run_len == `SACU_CYC_SUB)
    else $error("subtract took the wrong number of cycles");

  a_swap_wide:
  assert property (s_finish(OP_SWAP32) |=>
    {r.stk[r.ptr], r.stk[i1]} == $past(b32))
    else $error("wide exchange lost its operand");

  a_swap_narrow:
  assert property (s_finish(OP_SWAP16) |-> r.run_len == `SACU_CYC_SWAP16)
    else $error("narrow exchange took the wrong number of cycles");

  a_stall_held:
  assert property (s_accept |=> stall [*8])
    else $error("host port released too early");

endmodule

// ### verif/sacu_host_model.sv
`timescale 1ns/1ps

module sacu_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Service request handshake
  input wire logic srq,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  output logic svc_ack
);
  logic [3:0] wait_cnt;

  // A slow host lets ack_delay cycles pass before it answers a request,
  // and drops its acknowledge once the request has gone away.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wait_cnt <= 4'h0;
      svc_ack <= 1'b0;
    end else if (srq && ack_en) begin
      if (wait_cnt == ack_delay) begin
        svc_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      wait_cnt <= 4'h0;
      svc_ack <= 1'b0;
    end
  end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic addr = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [15:0] rd_data;
  logic stall;
  logic srq;
  logic svc_ack;
  logic ack_en = 1'b1;
  logic [3:0] ack_delay = 4'h3;
  logic [15:0] v;
  logic [7:0] codes [4] = '{8'hB9, 8'h39, 8'h99, 8'h19};
  int error_cnt = 0;
  int total_checks = 0;

  always #10 sys_clk = ~sys_clk;

  // The tangent count is shortened so the run stays brief.
  sacu_core #(.TAN_CYCLES(13'h0028)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rd_data(rd_data), .stall(stall), .srq(srq), .svc_ack(svc_ack)
  );

  sacu_host_model u_host (
    .sys_clk(sys_clk), .reset_n(reset_n), .srq(srq), .ack_en(ack_en),
    .ack_delay(ack_delay), .svc_ack(svc_ack)
  );

  task results;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task check(input string name, input logic [15:0] seen,
             input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wr(input logic a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
  endtask

  // Read data are taken in the single cycle after the strobe.
  task rd(input logic a, output logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    #1 d = rd_data;
  endtask

  task push(input logic [15:0] d);
    wr(1'b0, d);
  endtask

  task pchk(input logic [15:0] e);
    rd(1'b0, v);
    check("stack", v, e);
  endtask

  task rst;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask

  // Issues one command, counts its busy cycles and checks status bits.
  task run(input logic [7:0] opc, input int n, input logic [7:0] mask,
           input logic [7:0] exp);
    int cnt;
    cnt = 0;
    wr(1'b1, {8'h00, opc});
    #1;
    while (stall === 1'b1 && cnt < 9000) begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
    check("cycles", cnt[15:0], n[15:0]);
    check("srq", {15'h0000, srq}, {15'h0000, opc[7]});
    rd(1'b1, v);
    check("status", v & {8'h00, mask}, {8'h00, exp});
  endtask

  initial begin
    #(20 * 40000);
    error_cnt++;
    results();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(1'b1, v);
    check("status_reset", v, 16'h0000);
    push(16'h0055);
    push(16'h7FFF);
    push(16'h0001);
    run(8'hEC, 16, 8'hFF, 8'h44);
    pchk(16'h8000);
    pchk(16'h0055);
    repeat (8) @(posedge sys_clk);
    check("srq_ack", {15'h0000, srq}, 16'h0000);
    push(16'hFFFF);
    push(16'h0001);
    run(8'h6C, 16, 8'hFF, 8'h21);
    pchk(16'h0000);
    push(16'h0000);
    push(16'h0001);
    run(8'hED, 30, 8'hFF, 8'h41);
    pchk(16'hFFFF);
    push(16'h0000);
    push(16'h8000);
    run(8'h6D, 30, 8'hFF, 8'h45);
    pchk(16'h8000);
    push(16'h1111);
    push(16'h2222);
    run(8'hF9, 18, 8'hFF, 8'h05);
    run(8'h79, 18, 8'hFF, 8'h05);
    run(8'hF9, 18, 8'hFF, 8'h05);
    pchk(16'h1111);
    pchk(16'h2222);
    rst();
    push(16'h0007);
    push(16'h0002);
    run(8'hEF, 84, 8'hFF, 8'h00);
    pchk(16'h0003);
    push(16'hFFF9);
    push(16'h0002);
    run(8'h6F, 84, 8'hFF, 8'h40);
    pchk(16'hFFFD);
    push(16'h0005);
    push(16'h0000);
    run(8'hEF, 14, 8'hFF, 8'h10);
    pchk(16'h0005);
    rst();
    push(16'h0003);
    push(16'h0004);
    run(8'hEE, 84, 8'hFF, 8'h00);
    pchk(16'h000C);
    push(16'h8000);
    push(16'h0003);
    run(8'h6E, 84, 8'hFF, 8'h44);
    pchk(16'h8000);
    rst();
    push(16'h4000);
    push(16'h0004);
    run(8'hF6, 80, 8'hFF, 8'h00);
    pchk(16'h0001);
    push(16'h0002);
    push(16'h8000);
    run(8'h76, 80, 8'hFF, 8'h44);
    pchk(16'h8000);
    rst();
    push(16'h0000);
    push(16'h0380);
    run(8'h81, 782, 8'hFE, 8'h00);
    pchk(16'h0280);
    pchk(16'h0000);
    push(16'h0000);
    push(16'h8380);
    run(8'h01, 782, 8'h1E, 8'h08);
    rd(1'b0, v);
    rd(1'b0, v);
    push(16'h0000);
    push(16'h7580);
    run(8'h82, 30, 8'h7E, 8'h08);
    pchk(16'h7580);
    pchk(16'h0000);
    push(16'h0000);
    push(16'h0180);
    run(8'h02, 3796, 8'h60, 8'h00);
    rd(1'b0, v);
    rd(1'b0, v);
    push(16'h0000);
    push(16'hF580);
    run(8'h84, 30, 8'h60, 8'h40);
    pchk(16'hF580);
    pchk(16'h0000);
    push(16'h0FDB);
    push(16'h01C9);
    run(8'h04, 40, 8'h1E, 8'h04);
    rd(1'b0, v);
    rd(1'b0, v);
    for (int i = 0; i < 4; i++) begin
      push(16'h1111);
      push(16'h2222);
      push(16'h3333);
      push(16'h4444);
      run(codes[i], 26, 8'h60, 8'h00);
      pchk(16'h2222);
      pchk(16'h1111);
      pchk(16'h4444);
      pchk(16'h3333);
    end
    // Accesses made while a command runs must leave no trace.
    rst();
    push(16'h0003);
    push(16'h0004);
    wr(1'b1, 16'h00EE);
    rd(1'b1, v);
    check("busy", v & 16'h0080, 16'h0080);
    rd(1'b0, v);
    check("busy_read", v, 16'h0000);
    push(16'h9999);
    wr(1'b1, 16'h00EC);
    for (int i = 0; i < 200 && stall === 1'b1; i++) begin
      @(posedge sys_clk);
    end
    pchk(16'h000C);
    pchk(16'h0000);
    wr(1'b1, 16'h0000);
    #1;
    check("unknown_op", {15'h0000, stall}, 16'h0000);
    // A low enable must stretch a command by the frozen cycles; the pushes
    // also carry the head pointer across the end of the ring.
    push(16'h0002);
    push(16'h0003);
    wr(1'b1, 16'h006C);
    ce <= 1'b0;
    repeat (5) @(posedge sys_clk);
    ce <= 1'b1;
    v = 16'h0000;
    #1;
    while (stall === 1'b1 && v < 16'h00C8) begin
      @(posedge sys_clk);
      #1;
      v++;
    end
    check("ce_freeze", v, 16'h0010);
    pchk(16'h0005);
    results();
  end
endmodule
